/* File: hdl/i2c_ctl_consts.vh */
// register map, field positions and bus timing for the i2c control sequencer
`ifndef I2C_CTL_CONSTS_VH
`define I2C_CTL_CONSTS_VH

// ==========================================================
// register byte offsets
`define OFS_CONTROL_LOW   8'h00
`define OFS_CONFIG        8'h04
`define OFS_TX_DATA       8'h08
`define OFS_STATUS        8'h0c

// ==========================================================
// bus_control_low fields
`define BIT_START_REQ     0
`define BIT_RESTART_REQ   1
`define BIT_STOP_REQ      2
`define BIT_RECEIVE_REQ   3
`define BIT_ACK_SEQ_REQ   4
`define BIT_ACK_VALUE     5
`define BIT_STRETCH_ALLOW 6
`define BIT_GCALL_ACCEPT  7
`define CONTROL_RESET     16'h0000

// ==========================================================
// config fields
`define BIT_MASTER_MODE   0
`define BIT_ADDR_HOLD     1
`define BIT_DATA_HOLD     2
`define BIT_CLOCK_RELEASE 3
`define CONFIG_RESET      16'h0008

// ==========================================================
// status fields
`define BIT_MASTER_BUSY   8
`define BIT_RX_FULL       9
`define BIT_GCALL_SEEN    10
`define BIT_ADDRESSED     11
`define BIT_SLAVE_TX      12
`define BIT_SCL_HELD      13
`define BIT_NACK_SEEN     14

// ==========================================================
// timing: one bit on the wire, split into four quarters
`define CLK_PERIOD_NS     50
`define BIT_TIME_NS       10000
`define QUARTER_CYCLES    (`BIT_TIME_NS / (4 * `CLK_PERIOD_NS))

`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

/* File: hdl/i2c_control_low_sequencer.v */
// i2c control-low sequencer: master start/restart/stop/receive/ack, slave address and data
`timescale 1ns/1ps
`include "i2c_ctl_consts.vh"

module i2c_control_low_sequencer #(
    parameter ADDR_W  = 8,
    parameter QUARTER = `QUARTER_CYCLES
) (
    input  wire              aclk,
    input  wire              aresetn,
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output wire              s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output wire              s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output wire              s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    input  wire              scl_in,
    output wire              scl_out,
    output reg               scl_oe_n,
    input  wire              sda_in,
    output wire              sda_out,
    output reg               sda_oe_n
);

    // ==========================================================
    // helpers
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0]  strb;
        begin
            merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
        end
    endfunction

    function mapped;
        input [ADDR_W-1:0] a;
        begin
            mapped = (a == `OFS_CONTROL_LOW) || (a == `OFS_CONFIG) ||
                     (a == `OFS_TX_DATA) || (a == `OFS_STATUS);
        end
    endfunction

    // ==========================================================
    // state
    localparam M_IDLE = 3'd0, M_START = 3'd1, M_RESTART = 3'd2, M_STOP = 3'd3;
    localparam M_RX = 3'd4, M_ACK = 3'd5;
    localparam S_IDLE = 3'd0, S_ADDR = 3'd1, S_AACK = 3'd2, S_RX = 3'd3;
    localparam S_RACK = 3'd4, S_TX = 3'd5, S_TACK = 3'd6;

    reg [15:0]       ctrl_r;
    reg [15:0]       cfg_r;
    reg [7:0]        tx_data_r;
    reg [7:0]        rx_data_r;
    reg              rx_full_r, gc_seen_r, nack_seen_r, addressed_r;
    reg              aw_have_r, w_have_r;
    reg [ADDR_W-1:0] aw_addr_r;
    reg [31:0]       w_data_r;
    reg [3:0]        w_strb_r;
    reg [2:0]        m_state_r, s_state_r;
    reg [1:0]        phase_r;
    reg [15:0]       qcnt_r;
    reg [3:0]        m_bit_r, s_cnt_r;
    reg [7:0]        m_shift_r, s_shift_r;
    reg              m_scl_low_r, m_sda_low_r, s_scl_low_r, s_sda_low_r;
    reg              s_gcall_r, s_ack_ok_r;
    reg              scl_m_r, scl_s_r, scl_p_r, sda_m_r, sda_s_r, sda_p_r;

    // ==========================================================
    // pin synchronisers; only the second stage and its delayed copy feed logic
    always @(posedge aclk) begin
        if (!aresetn) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_p_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_p_r <= 1'b1;
        end else begin
            scl_m_r <= scl_in;
            scl_s_r <= scl_m_r;
            scl_p_r <= scl_s_r;
            sda_m_r <= sda_in;
            sda_s_r <= sda_m_r;
            sda_p_r <= sda_s_r;
        end
    end

    wire scl_rise   = scl_s_r & ~scl_p_r;
    wire scl_fall   = ~scl_s_r & scl_p_r;
    wire bus_start  = scl_s_r & scl_p_r & sda_p_r & ~sda_s_r;
    wire bus_stop   = scl_s_r & scl_p_r & ~sda_p_r & sda_s_r;
    wire master_mode = cfg_r[`BIT_MASTER_MODE];
    wire stretch_ok  = ctrl_r[`BIT_STRETCH_ALLOW];
    wire ack_value   = ctrl_r[`BIT_ACK_VALUE];

    // open-drain: only ever pull low, enable is active low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    always @(posedge aclk) begin
        if (!aresetn) begin
            scl_oe_n <= 1'b1;
            sda_oe_n <= 1'b1;
        end else begin
            scl_oe_n <= ~(m_scl_low_r | s_scl_low_r);
            sda_oe_n <= ~(m_sda_low_r | s_sda_low_r);
        end
    end

    // ==========================================================
    // axi4-lite slave
    assign s_axi_awready = ~aw_have_r;
    assign s_axi_wready  = ~w_have_r;
    assign s_axi_arready = ~s_axi_rvalid;
    wire wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;
    wire wr_ctrl = wr_go && (aw_addr_r == `OFS_CONTROL_LOW);
    wire wr_cfg  = wr_go && (aw_addr_r == `OFS_CONFIG);
    wire wr_stat = wr_go && (aw_addr_r == `OFS_STATUS) && w_strb_r[1];
    wire [15:0] wr_ctrl_val = merge16(ctrl_r, w_data_r, w_strb_r);
    wire [15:0] wr_cfg_val  = merge16(cfg_r, w_data_r, w_strb_r);

    wire [15:0] status = {1'b0, nack_seen_r, s_scl_low_r, (s_state_r == S_TX), addressed_r,
                          gc_seen_r, rx_full_r, (m_state_r != M_IDLE), rx_data_r};

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            aw_addr_r    <= {ADDR_W{1'b0}};
            w_data_r     <= 32'h00000000;
            w_strb_r     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= `RESP_OKAY;
            s_axi_rdata  <= 32'h00000000;
            tx_data_r    <= 8'h00;
        end else begin
            if (s_axi_awvalid && !aw_have_r) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_have_r) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
                if (aw_addr_r == `OFS_TX_DATA && w_strb_r[0])
                    tx_data_r <= w_data_r[7:0];
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && !s_axi_rvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
                case (s_axi_araddr)
                    `OFS_CONTROL_LOW: s_axi_rdata <= {24'h000000, ctrl_r[7:0]};
                    `OFS_CONFIG:      s_axi_rdata <= {16'h0000, cfg_r};
                    `OFS_TX_DATA:     s_axi_rdata <= {24'h000000, tx_data_r};
                    `OFS_STATUS:      s_axi_rdata <= {16'h0000, status};
                    default:          s_axi_rdata <= 32'h00000000;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // master sequencer, quarter-bit phases: two for start, three for stop, four per bit otherwise
    wire qtick = (qcnt_r == QUARTER - 1);
    wire m_done = (m_state_r != M_IDLE) && qtick &&
                  ((m_state_r == M_START && phase_r == 2'd1) ||
                   (m_state_r == M_STOP && phase_r == 2'd2) ||
                   (m_state_r == M_RX && phase_r == 2'd3 && m_bit_r == 4'd7) ||
                   ((m_state_r == M_RESTART || m_state_r == M_ACK) && phase_r == 2'd3));

    // slave-side hardware clear events
    wire s_tx_begin = scl_fall && ((s_state_r == S_AACK && s_shift_r[0]) ||
                                   (s_state_r == S_TACK && s_ack_ok_r));
    wire s_rx_end   = scl_fall && s_state_r == S_RX && s_cnt_r == 4'd8;

    // ==========================================================
    // control and config registers: software sets, hardware clears
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= `CONTROL_RESET;
            cfg_r  <= `CONFIG_RESET;
        end else begin
            if (m_done) begin
                ctrl_r[`BIT_START_REQ]   <= 1'b0;
                ctrl_r[`BIT_RESTART_REQ] <= 1'b0;
                ctrl_r[`BIT_STOP_REQ]    <= 1'b0;
                ctrl_r[`BIT_RECEIVE_REQ] <= 1'b0;
                ctrl_r[`BIT_ACK_SEQ_REQ] <= 1'b0;
            end
            if (s_tx_begin)
                ctrl_r[`BIT_ACK_VALUE] <= 1'b0;
            if (s_tx_begin || s_rx_end)
                cfg_r[`BIT_CLOCK_RELEASE] <= 1'b0;
            if (wr_ctrl)
                ctrl_r <= {8'h00, wr_ctrl_val[7:0]};
            if (wr_cfg)
                cfg_r <= {1'b0, wr_cfg_val[14:8], 4'h0, wr_cfg_val[3:0]};
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            m_state_r   <= M_IDLE;
            phase_r     <= 2'd0;
            qcnt_r      <= 16'h0000;
            m_bit_r     <= 4'h0;
            m_shift_r   <= 8'h00;
            m_scl_low_r <= 1'b0;
            m_sda_low_r <= 1'b0;
        end else if (!master_mode) begin
            m_state_r   <= M_IDLE;
            m_scl_low_r <= 1'b0;
            m_sda_low_r <= 1'b0;
        end else if (m_state_r == M_IDLE) begin
            phase_r <= 2'd0;
            qcnt_r  <= 16'h0000;
            m_bit_r <= 4'h0;
            // one request at a time; a lower bit simply wins
            if (ctrl_r[`BIT_START_REQ])
                m_state_r <= M_START;
            else if (ctrl_r[`BIT_RESTART_REQ])
                m_state_r <= M_RESTART;
            else if (ctrl_r[`BIT_STOP_REQ])
                m_state_r <= M_STOP;
            else if (ctrl_r[`BIT_RECEIVE_REQ])
                m_state_r <= M_RX;
            else if (ctrl_r[`BIT_ACK_SEQ_REQ])
                m_state_r <= M_ACK;
        end else begin
            qcnt_r <= qtick ? 16'h0000 : qcnt_r + 16'h0001;
            if (qtick) begin
                phase_r <= phase_r + 2'd1;
                case (m_state_r)
                    M_START: begin
                        if (phase_r == 2'd0) m_sda_low_r <= 1'b1;
                        else m_scl_low_r <= 1'b1;
                    end
                    M_RESTART: begin
                        case (phase_r)
                            2'd0:    m_sda_low_r <= 1'b0;
                            2'd1:    m_scl_low_r <= 1'b0;
                            2'd2:    m_sda_low_r <= 1'b1;
                            default: m_scl_low_r <= 1'b1;
                        endcase
                    end
                    M_STOP: begin
                        case (phase_r)
                            2'd0:    m_sda_low_r <= 1'b1;
                            2'd1:    m_scl_low_r <= 1'b0;
                            default: m_sda_low_r <= 1'b0;
                        endcase
                    end
                    M_RX: begin
                        case (phase_r)
                            2'd0:    m_sda_low_r <= 1'b0;
                            2'd1:    m_scl_low_r <= 1'b0;
                            2'd2:    m_shift_r <= {m_shift_r[6:0], sda_s_r};
                            default: begin
                                m_scl_low_r <= 1'b1;
                                m_bit_r     <= m_bit_r + 4'h1;
                            end
                        endcase
                    end
                    M_ACK: begin
                        case (phase_r)
                            2'd0:    m_sda_low_r <= ~ack_value;
                            2'd1:    m_scl_low_r <= 1'b0;
                            2'd2:    m_scl_low_r <= 1'b0;
                            default: m_scl_low_r <= 1'b1;
                        endcase
                    end
                    default: m_state_r <= M_IDLE;
                endcase
                // an ack's sda is let go by the next step, never as scl falls
                if (m_done) m_state_r <= M_IDLE;
            end
        end
    end

    // ==========================================================
    // slave receiver/transmitter and status flags
    wire addr_match = (s_shift_r[7:1] == cfg_r[14:8]) && (s_shift_r[7:1] != 7'h00);
    wire gcall_hit  = (s_shift_r == 8'h00) && ctrl_r[`BIT_GCALL_ACCEPT];
    wire hold_ack   = cfg_r[`BIT_ADDR_HOLD] | cfg_r[`BIT_DATA_HOLD];

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_state_r   <= S_IDLE;
            s_cnt_r     <= 4'h0;
            s_shift_r   <= 8'h00;
            s_scl_low_r <= 1'b0;
            s_sda_low_r <= 1'b0;
            s_gcall_r   <= 1'b0;
            s_ack_ok_r  <= 1'b0;
            rx_data_r   <= 8'h00;
            rx_full_r   <= 1'b0;
            gc_seen_r   <= 1'b0;
            nack_seen_r <= 1'b0;
            addressed_r <= 1'b0;
        end else begin
            // status write-one-to-clear; a same-cycle hardware set below wins
            if (wr_stat && w_data_r[`BIT_RX_FULL])    rx_full_r   <= 1'b0;
            if (wr_stat && w_data_r[`BIT_GCALL_SEEN]) gc_seen_r   <= 1'b0;
            if (wr_stat && w_data_r[`BIT_NACK_SEEN])  nack_seen_r <= 1'b0;
            if (m_done && m_state_r == M_RX) begin
                rx_data_r <= m_shift_r;
                rx_full_r <= 1'b1;
            end
            if (s_scl_low_r && cfg_r[`BIT_CLOCK_RELEASE])
                s_scl_low_r <= 1'b0;
            if (master_mode || bus_stop) begin
                s_state_r   <= S_IDLE;
                s_sda_low_r <= 1'b0;
                s_scl_low_r <= 1'b0;
                addressed_r <= 1'b0;
            end else if (bus_start) begin
                s_state_r   <= S_ADDR;
                s_cnt_r     <= 4'h0;
                s_sda_low_r <= 1'b0;
                addressed_r <= 1'b0;
            end else begin
                case (s_state_r)
                    S_ADDR, S_RX: begin
                        if (scl_rise && s_cnt_r != 4'd8) begin
                            s_shift_r <= {s_shift_r[6:0], sda_s_r};
                            s_cnt_r   <= s_cnt_r + 4'h1;
                        end
                        if (scl_fall && s_cnt_r == 4'd8) begin
                            s_cnt_r <= 4'h0;
                            if (s_state_r == S_RX) begin
                                rx_data_r   <= s_shift_r;
                                rx_full_r   <= 1'b1;
                                s_sda_low_r <= cfg_r[`BIT_DATA_HOLD] ? ~ack_value : 1'b1;
                                s_scl_low_r <= stretch_ok;
                                s_state_r   <= S_RACK;
                            end else if (addr_match || gcall_hit) begin
                                s_gcall_r   <= gcall_hit & ~addr_match;
                                if (gcall_hit && !addr_match)
                                    gc_seen_r <= 1'b1;
                                addressed_r <= 1'b1;
                                s_sda_low_r <= hold_ack ? ~ack_value : 1'b1;
                                s_state_r   <= S_AACK;
                            end else begin
                                s_state_r <= S_IDLE;
                            end
                        end
                    end
                    S_AACK, S_TACK: begin
                        if (scl_rise && s_state_r == S_TACK) begin
                            s_ack_ok_r <= ~sda_s_r;
                            if (sda_s_r) nack_seen_r <= 1'b1;
                        end
                        if (scl_fall) begin
                            s_sda_low_r <= 1'b0;
                            if (s_tx_begin && !s_gcall_r) begin
                                s_shift_r   <= {tx_data_r[6:0], 1'b0};
                                s_sda_low_r <= ~tx_data_r[7];
                                s_cnt_r     <= 4'h1;
                                s_scl_low_r <= stretch_ok;
                                s_state_r   <= S_TX;
                            end else if (s_state_r == S_AACK && !s_shift_r[0]) begin
                                s_state_r <= S_RX;
                            end else begin
                                s_state_r <= S_IDLE;
                            end
                        end
                    end
                    S_RACK: begin
                        if (scl_fall) begin
                            s_sda_low_r <= 1'b0;
                            s_state_r   <= S_RX;
                        end
                    end
                    S_TX: begin
                        if (scl_fall) begin
                            if (s_cnt_r == 4'd8) begin
                                s_sda_low_r <= 1'b0;
                                s_state_r   <= S_TACK;
                            end else begin
                                s_sda_low_r <= ~s_shift_r[7];
                                s_shift_r   <= {s_shift_r[6:0], 1'b0};
                                s_cnt_r     <= s_cnt_r + 4'h1;
                            end
                        end
                    end
                    default: s_state_r <= S_IDLE;
                endcase
            end
        end
    end

endmodule // i2c_control_low_sequencer

/* File: test/i2c_ctl_properties.sv */
// port assertions for the i2c control sequencer
`timescale 1ns/1ps
`include "i2c_ctl_consts.vh"
module i2c_ctl_properties #(
    parameter ADDR_W = 8
) (
    input wire              aclk,
    input wire              aresetn,
    input wire [1:0]        s_axi_bresp,
    input wire              s_axi_bvalid,
    input wire              s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire              s_axi_arvalid,
    input wire              s_axi_arready,
    input wire [31:0]       s_axi_rdata,
    input wire [1:0]        s_axi_rresp,
    input wire              s_axi_rvalid,
    input wire              s_axi_rready,
    input wire              scl_oe_n,
    input wire              sda_oe_n
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ==========================================================
    // bus handshakes
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while busy");
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0c
        |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
    a_ctrl_upper: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00
        |=> s_axi_rresp == `RESP_OKAY && s_axi_rdata[31:8] == 24'h0) else $error("control read");
    // ==========================================================
    // pins; a master low phase lasts at least one quarter
    a_scl_low_min: assert property ($fell(scl_oe_n) |=> !scl_oe_n [*3])
        else $error("scl low phase too short");
    a_reset_idle: assert property ($rose(aresetn) |-> scl_oe_n && sda_oe_n)
        else $error("pins driven after reset");
    cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
    cover property ($fell(scl_oe_n));
    cover property (!sda_oe_n && scl_oe_n);
endmodule // i2c_ctl_properties

bind i2c_control_low_sequencer i2c_ctl_properties #(.ADDR_W(ADDR_W)) u_props (.aclk,
    .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scl_oe_n,
    .sda_oe_n);

/* File: test/i2c_far_end.sv */
// far-end party: slave transmitter for master receive, bus master for slave tests
`timescale 1ns/1ps
module i2c_far_end (
    input  wire scl,
    input  wire sda,
    output reg  scl_rel,
    output reg  sda_rel
);
    integer   starts = 0;
    integer   stops = 0;
    integer   rises = 0;
    reg [7:0] tx_r;
    reg       tx_on = 0;
    reg       ack_seen = 1;
    initial scl_rel = 1;
    initial sda_rel = 1;
    always @(negedge sda) if (scl) starts = starts + 1;
    always @(posedge sda) if (scl) stops = stops + 1;
    always @(posedge scl) begin
        rises = rises + 1;
        ack_seen = sda;
    end
    // next bit only while scl is low; ones shifted in release sda after the byte
    always @(negedge scl) if (tx_on) begin
        sda_rel = tx_r[7];
        tx_r = {tx_r[6:0], 1'b1};
    end
    task load(input [7:0] b);
        begin
            sda_rel = b[7];
            tx_r = {b[6:0], 1'b1};
            tx_on = 1;
        end
    endtask
    // 400 ns bit period; scl stands still between frames
    task frame(input [7:0] b, output ack);
        integer i;
        begin
            #10 scl_rel = 1;
            #200 sda_rel = 0;
            #200 scl_rel = 0;
            for (i = 8; i >= 0; i = i - 1) begin
                #100 sda_rel = (i == 0) ? 1'b1 : b[i-1];
                #100 scl_rel = 1;
                #200 ack = sda;
                scl_rel = 0;
            end
            #100 sda_rel = 0;
            #100 scl_rel = 1;
            #200 sda_rel = 1;
            #200;
        end
    endtask
endmodule // i2c_far_end

/* File: test/i2c_control_low_sequencer_tb_top.sv */
// self-checking bench for the i2c control sequencer
`timescale 1ns/1ps
`include "i2c_ctl_consts.vh"
module i2c_control_low_sequencer_tb_top;
    reg  [7:0]  awaddr, araddr;
    reg  [31:0] wdata, v;
    reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ak, t, u;
    wire        awready, wready, bvalid, arready, rvalid, scl_oe_n, sda_oe_n, scl_rel, sda_rel;
    wire [1:0]  bresp, rresp;
    reg  [1:0]  r;
    wire [31:0] rdata;
    wire        scl = scl_oe_n & scl_rel;
    wire        sda = sda_oe_n & sda_rel;
    integer     failures, tests_run, cycles, i, n0;
    i2c_control_low_sequencer #(.QUARTER(4)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .scl_in(scl), .scl_out(), .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(),
        .sda_oe_n(sda_oe_n));
    i2c_far_end p (.scl(scl), .sda(sda), .scl_rel(scl_rel), .sda_rel(sda_rel));
    task conclude;
        begin
            $display("comparisons %0d, mismatches %0d", tests_run, failures);
            if (failures == 0 && tests_run > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // handshake flags are looked at mid-cycle, acted on at the next rising edge
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge aclk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1;
            wvalid <= 1;
            bready <= 1;
            u = 1;
            while (u) begin
                @(negedge aclk);
                t = awvalid & awready;
                ak = wvalid & wready;
                if (bvalid) r = bresp;
                u = !bvalid;
                @(posedge aclk);
                if (t) awvalid <= 0;
                if (ak) wvalid <= 0;
                if (!u) bready <= 0;
            end
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1;
            rready <= 1;
            u = 1;
            while (u) begin
                @(negedge aclk);
                t = arvalid & arready;
                if (rvalid) {v, r} = {rdata, rresp};
                u = !rvalid;
                @(posedge aclk);
                if (t) arvalid <= 0;
                if (!u) rready <= 0;
            end
        end
    endtask
    task poll(input integer n);
        integer k;
        begin
            v = 32'hff;
            for (k = 0; k < 100 && v[n]; k = k + 1) rd(`OFS_CONTROL_LOW);
            chk(v[n], 0);
        end
    endtask
    initial begin
        aclk = 0;
        forever #25 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures = failures + 1;
            $display("wrong value at %0t ns: timeout", $time);
            conclude;
        end
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = 0;
        {failures, tests_run, cycles} = 0;
        v = $urandom(98);
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        rd(`OFS_CONTROL_LOW);
        chk(v, `CONTROL_RESET);
        rd(`OFS_CONFIG);
        chk(v, `CONFIG_RESET);
        rd(8'h10);
        chk(v, 0);
        chk(r, `RESP_SLVERR);
        wr(8'h10, 32'hff);
        chk(r, `RESP_SLVERR);
        wr(`OFS_CONFIG, 32'h9);
        n0 = p.starts;
        wr(`OFS_CONTROL_LOW, 32'h1);
        poll(`BIT_START_REQ);
        chk(p.starts - n0, 1);
        i = $urandom;
        p.load(i[7:0]);
        n0 = p.rises;
        wr(`OFS_CONTROL_LOW, 32'h8);
        poll(`BIT_RECEIVE_REQ);
        chk(p.rises - n0, 8);
        rd(`OFS_STATUS);
        chk(v[7:0], i[7:0]);
        p.tx_on = 0;
        wr(`OFS_CONTROL_LOW, {26'h0, i[8], 5'h10});
        poll(`BIT_ACK_SEQ_REQ);
        chk(p.ack_seen, i[8]);
        n0 = p.starts;
        wr(`OFS_CONTROL_LOW, 32'h2);
        poll(`BIT_RESTART_REQ);
        chk(p.starts - n0, 1);
        n0 = p.stops;
        wr(`OFS_CONTROL_LOW, 32'h4);
        poll(`BIT_STOP_REQ);
        chk(p.stops - n0, 1);
        // slave: general call accepted, ignored, then answered from ack_value under hold
        for (i = 0; i < 3; i = i + 1) begin
            wr(`OFS_CONFIG, (i == 2) ? 32'ha : 32'h8);
            wr(`OFS_CONTROL_LOW, (i == 0) ? 32'h80 : (i == 1) ? 32'h0 : 32'ha0);
            wr(`OFS_STATUS, 32'h400);
            p.frame(8'h00, ak);
            chk(ak, i != 0);
            rd(`OFS_STATUS);
            chk(v[`BIT_GCALL_SEEN], i != 1);
        end
        wr(`OFS_CONFIG, 32'h2a08);
        wr(`OFS_CONTROL_LOW, 32'h60);
        p.frame(8'h55, ak);
        rd(`OFS_STATUS);
        chk(v[`BIT_SCL_HELD], 1);
        rd(`OFS_CONTROL_LOW);
        chk(v[`BIT_ACK_VALUE], 0);
        rd(`OFS_CONFIG);
        chk(v[`BIT_CLOCK_RELEASE], 0);
        conclude;
    end
endmodule // i2c_control_low_sequencer_tb_top
